// ---- rtl/mees_pkg.sv ----
// Constants for the mesh egress event selector: event codes, sub-select
// masks, register map and control field positions.
// Assumes a single clock domain and an APB register bus with 32-bit data.

`default_nettype none

package mees_pkg;

    // Event codes
    localparam logic [7:0] EV_HORZ_STARVED   = 8'ha5;
    localparam logic [7:0] EV_VERT_ESCAPE    = 8'h9c;
    localparam logic [7:0] EV_VERT_BYPASS    = 8'h9d;
    localparam logic [7:0] EV_VERT_BYPASS_2  = 8'h9e;
    localparam logic [7:0] EV_VERT_FULL_MAIN = 8'h94;
    localparam logic [7:0] EV_VERT_FULL_2ND  = 8'h95;
    localparam logic [7:0] EV_VERT_NONEMPTY  = 8'h96;

    // Sub-select bits that each event honours
    localparam logic [7:0] MASK_HORZ_STARVED = 8'h8f;
    localparam logic [7:0] MASK_VERT_ESCAPE  = 8'h55;
    localparam logic [7:0] MASK_VERT_SEVEN   = 8'h7f;
    localparam logic [7:0] MASK_VERT_SECOND  = 8'h03;

    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_CNT_LO = 12'h004;
    localparam logic [11:0] ADDR_CNT_HI = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;

    // Control register fields
    localparam int CTRL_CODE_LSB    = 0;
    localparam int CTRL_SUBSEL_LSB  = 8;
    localparam int CTRL_ENABLE_BIT  = 16;
    localparam int CTRL_NOTFULL_BIT = 17;
    localparam int CTRL_CLEAR_BIT   = 18;
    localparam int CTRL_FREEZE_BIT  = 19;

    // Status register fields
    localparam int STAT_VALID_BIT   = 0;
    localparam int STAT_OVF_BIT     = 1;
    localparam int STAT_INC_LSB     = 8;

    // Reset values
    localparam logic [7:0] RST_CODE   = 8'h00;
    localparam logic [7:0] RST_SUBSEL = 8'h00;

    // Number of set bits in a byte
    function automatic logic [3:0] mees_popcount(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : mees_popcount

endpackage : mees_pkg

`default_nettype wire

// ---- rtl/mees_event_select.sv ----
// Event selector: picks the raw condition vector that the event code names,
// gates it with the sub-select and the bits that event honours, and counts.
// Assumes condition vectors are same-clock levels, bit-aligned to sub-select.

`default_nettype none

module mees_event_select (
    input  wire logic [7:0] event_code,
    input  wire logic [7:0] sub_select,
    input  wire logic       count_not_full,
    input  wire logic [7:0] horizontal_injection_starvation,
    input  wire logic [7:0] vertical_escape_slot_used,
    input  wire logic [7:0] vertical_egress_bypass,
    input  wire logic [1:0] vertical_egress_bypass_second,
    input  wire logic [6:0] vertical_queue_full_cycles_main,
    input  wire logic [1:0] vertical_queue_full_cycles_second,
    input  wire logic [6:0] vertical_queue_nonempty_cycles,
    output logic            code_valid,
    output logic [3:0]      increment
);

    logic [7:0] cond;
    logic [7:0] honoured;
    logic [7:0] fill_main;
    logic [7:0] fill_second;

    // Full cycles by default; the inverted view counts not-full cycles
    assign fill_main   = count_not_full ? {1'b0, ~vertical_queue_full_cycles_main}
                                        : {1'b0,  vertical_queue_full_cycles_main};
    assign fill_second = count_not_full ? {6'h00, ~vertical_queue_full_cycles_second}
                                        : {6'h00,  vertical_queue_full_cycles_second};

    // Event code decode; unknown codes select nothing
    always_comb begin
        code_valid = 1'b1;
        cond       = 8'h00;
        honoured   = 8'h00;
        if (event_code == mees_pkg::EV_HORZ_STARVED) begin
            // Uncredited and all-traffic selections share one bit here
            cond     = horizontal_injection_starvation;
            honoured = mees_pkg::MASK_HORZ_STARVED;
        end else if (event_code == mees_pkg::EV_VERT_ESCAPE) begin
            cond     = vertical_escape_slot_used;
            honoured = mees_pkg::MASK_VERT_ESCAPE;
        end else if (event_code == mees_pkg::EV_VERT_BYPASS) begin
            cond     = vertical_egress_bypass;
            honoured = mees_pkg::MASK_VERT_SEVEN;
        end else if (event_code == mees_pkg::EV_VERT_BYPASS_2) begin
            cond     = {6'h00, vertical_egress_bypass_second};
            honoured = mees_pkg::MASK_VERT_SECOND;
        end else if (event_code == mees_pkg::EV_VERT_FULL_MAIN) begin
            cond     = fill_main;
            honoured = mees_pkg::MASK_VERT_SEVEN;
        end else if (event_code == mees_pkg::EV_VERT_FULL_2ND) begin
            cond     = fill_second;
            honoured = mees_pkg::MASK_VERT_SECOND;
        end else if (event_code == mees_pkg::EV_VERT_NONEMPTY) begin
            cond     = {1'b0, vertical_queue_nonempty_cycles};
            honoured = mees_pkg::MASK_VERT_SEVEN;
        end else begin
            code_valid = 1'b0;
        end
    end

    // Every selected sub-event that is true adds one this cycle
    assign increment = mees_pkg::mees_popcount(cond & honoured & sub_select);

endmodule : mees_event_select

`default_nettype wire

// ---- rtl/mees_top.sv ----
// Mesh egress event counter: APB register file, event selection and a
// wide counter of the selected egress conditions.
// Assumes the egress condition inputs are levels on the same clock as the
// APB bus, so they are used without synchronisers.

`default_nettype none

module mees_top #(
    parameter int CNT_W = 48
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Raw egress conditions, bit-aligned with the sub-select field
    input  wire logic [7:0]  horizontal_injection_starvation,
    input  wire logic [7:0]  vertical_escape_slot_used,
    input  wire logic [7:0]  vertical_egress_bypass,
    input  wire logic [1:0]  vertical_egress_bypass_second,
    input  wire logic [6:0]  vertical_queue_full_cycles_main,
    input  wire logic [1:0]  vertical_queue_full_cycles_second,
    input  wire logic [6:0]  vertical_queue_nonempty_cycles,
    // Counter state for neighbouring logic
    output logic             counter_overflow
);

    // Control state
    logic [7:0]       event_code;
    logic [7:0]       sub_select;
    logic             count_enable;
    logic             count_not_full;
    logic             freeze_on_ovf;

    // Counter state
    logic [CNT_W-1:0] counter;
    logic [CNT_W-1:0] next_counter;
    logic             carry_out;
    logic             ovf_sticky;
    logic [3:0]       last_increment;

    // Selector outputs
    logic             code_valid;
    logic [3:0]       increment;

    // Bus decode
    logic             setup_phase;
    logic             access_done;
    logic             wr_done;
    logic             hit_ctrl;
    logic             hit_cnt_lo;
    logic             hit_cnt_hi;
    logic             hit_status;
    logic             addr_mapped;
    logic [31:0]      read_mux;
    logic [31:0]      ctrl_view;
    logic [31:0]      status_view;
    logic [63:0]      counter_wide;
    logic             count_step;

    // Zero wait states: read data is latched in the setup cycle
    assign pready      = 1'b1;
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign wr_done     = access_done && pwrite;

    // Register decode; only whole aligned words are mapped
    always_comb begin
        hit_ctrl   = 1'b0;
        hit_cnt_lo = 1'b0;
        hit_cnt_hi = 1'b0;
        hit_status = 1'b0;
        if (paddr == mees_pkg::ADDR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == mees_pkg::ADDR_CNT_LO) begin
            hit_cnt_lo = 1'b1;
        end else if (paddr == mees_pkg::ADDR_CNT_HI) begin
            hit_cnt_hi = 1'b1;
        end else if (paddr == mees_pkg::ADDR_STATUS) begin
            hit_status = 1'b1;
        end
    end

    assign addr_mapped = hit_ctrl || hit_cnt_lo || hit_cnt_hi || hit_status;

    // Event selection and per-cycle increment
    mees_event_select i_mees_event_select (
        .event_code                        (event_code),
        .sub_select                        (sub_select),
        .count_not_full                    (count_not_full),
        .horizontal_injection_starvation   (horizontal_injection_starvation),
        .vertical_escape_slot_used         (vertical_escape_slot_used),
        .vertical_egress_bypass            (vertical_egress_bypass),
        .vertical_egress_bypass_second     (vertical_egress_bypass_second),
        .vertical_queue_full_cycles_main   (vertical_queue_full_cycles_main),
        .vertical_queue_full_cycles_second (vertical_queue_full_cycles_second),
        .vertical_queue_nonempty_cycles    (vertical_queue_nonempty_cycles),
        .code_valid                        (code_valid),
        .increment                         (increment)
    );

    // Read views of control and status
    always_comb begin
        ctrl_view = 32'h0000_0000;
        ctrl_view[mees_pkg::CTRL_CODE_LSB +: 8]   = event_code;
        ctrl_view[mees_pkg::CTRL_SUBSEL_LSB +: 8] = sub_select;
        ctrl_view[mees_pkg::CTRL_ENABLE_BIT]      = count_enable;
        ctrl_view[mees_pkg::CTRL_NOTFULL_BIT]     = count_not_full;
        ctrl_view[mees_pkg::CTRL_FREEZE_BIT]      = freeze_on_ovf;
    end

    always_comb begin
        status_view = 32'h0000_0000;
        status_view[mees_pkg::STAT_VALID_BIT]     = code_valid;
        status_view[mees_pkg::STAT_OVF_BIT]       = ovf_sticky;
        status_view[mees_pkg::STAT_INC_LSB +: 4]  = last_increment;
    end

    // Counter zero-extended to two words; upper bits beyond CNT_W read zero
    assign counter_wide = 64'(counter);

    always_comb begin
        read_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            read_mux = ctrl_view;
        end else if (hit_cnt_lo) begin
            read_mux = counter_wide[31:0];
        end else if (hit_cnt_hi) begin
            read_mux = counter_wide[63:32];
        end else if (hit_status) begin
            read_mux = status_view;
        end
    end

    // Read data and error answer, captured in the setup cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= pwrite ? 32'h0000_0000 : read_mux;
            pslverr <= !addr_mapped;
        end
    end

    // Control register; byte lanes honoured, clear bit is a write-only strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            event_code     <= mees_pkg::RST_CODE;
            sub_select     <= mees_pkg::RST_SUBSEL;
            count_enable   <= 1'b0;
            count_not_full <= 1'b0;
            freeze_on_ovf  <= 1'b0;
        end else if (wr_done && hit_ctrl) begin
            if (pstrb[0]) begin
                event_code <= pwdata[mees_pkg::CTRL_CODE_LSB +: 8];
            end
            if (pstrb[1]) begin
                sub_select <= pwdata[mees_pkg::CTRL_SUBSEL_LSB +: 8];
            end
            if (pstrb[2]) begin
                count_enable   <= pwdata[mees_pkg::CTRL_ENABLE_BIT];
                count_not_full <= pwdata[mees_pkg::CTRL_NOTFULL_BIT];
                freeze_on_ovf  <= pwdata[mees_pkg::CTRL_FREEZE_BIT];
            end
        end
    end

    // A counter that has wrapped may be told to hold its value
    assign count_step = count_enable && code_valid && (increment != 4'h0)
                        && !(freeze_on_ovf && ovf_sticky);

    // Add the whole per-cycle sum at once
    assign {carry_out, next_counter} = {1'b0, counter} + (CNT_W+1)'(increment);

    // Counter: software writes and clears win over counting in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            counter <= '0;
        end else if (wr_done && hit_ctrl && pstrb[2] && pwdata[mees_pkg::CTRL_CLEAR_BIT]) begin
            counter <= '0;
        end else if (wr_done && hit_cnt_lo) begin
            counter <= CNT_W'({counter_wide[63:32], pwdata});
        end else if (wr_done && hit_cnt_hi) begin
            counter <= CNT_W'({pwdata, counter_wide[31:0]});
        end else if (count_step) begin
            counter <= next_counter;
        end
    end

    // Overflow flag: a wrap in the clearing cycle keeps it set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovf_sticky <= 1'b0;
        end else if (count_step && carry_out) begin
            ovf_sticky <= 1'b1;
        end else if (wr_done && hit_status && pstrb[0] && pwdata[mees_pkg::STAT_OVF_BIT]) begin
            ovf_sticky <= 1'b0;
        end
    end

    // Last non-gated increment, for software to see activity
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_increment <= 4'h0;
        end else begin
            last_increment <= (count_enable && code_valid) ? increment : 4'h0;
        end
    end

    assign counter_overflow = ovf_sticky;

endmodule : mees_top

`default_nettype wire

// ---- verif/mees_top_assertions.sv ----
// Checker for the mesh egress event counter: APB answers, reset values,
// control read-back, code decode and the sticky overflow flag.
// Assumes it is bound to mees_top and sees only that module's ports.

`default_nettype none

module mees_top_checker #(
    parameter int CNT_W = 48
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        counter_overflow
);
    logic        acc;
    logic        mapped;
    logic [19:0] ctrl_q;

    // Access phase and register decode
    assign acc    = psel && penable;
    assign mapped = paddr inside {mees_pkg::ADDR_CTRL, mees_pkg::ADDR_CNT_LO,
                                  mees_pkg::ADDR_CNT_HI, mees_pkg::ADDR_STATUS};

    // Shadow of control; the clear bit never reads back, so it is kept at 0
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 20'h0;
        end else if (acc && pwrite && paddr == mees_pkg::ADDR_CTRL) begin
            if (pstrb[0]) ctrl_q[7:0] <= pwdata[7:0];
            if (pstrb[1]) ctrl_q[15:8] <= pwdata[15:8];
            if (pstrb[2]) ctrl_q[19:16] <= {pwdata[19], 1'b0, pwdata[17:16]};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_rd(logic [11:0] a);
        acc && !pwrite && paddr == a;
    endsequence

    property p_ready;       psel |-> pready; endproperty
    property p_err_map;     acc && mapped |-> !pslverr; endproperty
    property p_err_unmap;   acc && !mapped |-> pslverr; endproperty
    property p_rd_unmap;    acc && !pwrite && !mapped |-> prdata == 32'h0; endproperty
    property p_hold;        !psel |=> $stable(prdata); endproperty
    property p_rst_vals;    $rose(resetn) |-> prdata == 32'h0 && !pslverr && !counter_overflow; endproperty
    property p_ctrl_rd;     s_rd(mees_pkg::ADDR_CTRL) |-> prdata[19:0] == ctrl_q; endproperty
    property p_ovf_sticky;
        counter_overflow && !(acc && pwrite && paddr == mees_pkg::ADDR_STATUS) |=> counter_overflow;
    endproperty
    property p_code_valid;
        s_rd(mees_pkg::ADDR_STATUS) |-> prdata[0] == (ctrl_q[7:0] inside {8'ha5, 8'h9c, 8'h9d, 8'h9e,
                                                                           8'h94, 8'h95, 8'h96});
    endproperty

    a_ready:      assert property (p_ready) else $error("pready low during a transfer");
    a_err_map:    assert property (p_err_map) else $error("pslverr on a mapped register");
    a_err_unmap:  assert property (p_err_unmap) else $error("no pslverr on an unmapped address");
    a_rd_unmap:   assert property (p_rd_unmap) else $error("unmapped read data not zero");
    a_hold:       assert property (p_hold) else $error("prdata changed outside a transfer");
    a_rst_vals:   assert property (p_rst_vals) else $error("outputs not at reset values");
    a_ctrl_rd:    assert property (p_ctrl_rd) else $error("control read-back mismatch");
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped by itself");
    a_code_valid: assert property (p_code_valid) else $error("code valid bit wrong");
endmodule : mees_top_checker

bind mees_top mees_top_checker #(.CNT_W(CNT_W)) i_mees_top_checker (.clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .counter_overflow);

`default_nettype wire

// ---- verif/mees_top_tb.sv ----
// Self-checking bench for the mesh egress event counter: every event code,
// sub-select masks, fill polarity, overflow, register map.
// Assumes the checker file is compiled alongside and binds itself.

`default_nettype none

module mees_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, counter_overflow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_d;
    logic [3:0]  pstrb;
    logic [7:0]  horizontal_injection_starvation, vertical_escape_slot_used, vertical_egress_bypass;
    logic [1:0]  vertical_egress_bypass_second, vertical_queue_full_cycles_second;
    logic [6:0]  vertical_queue_full_cycles_main, vertical_queue_nonempty_cycles;
    logic        rd_e;
    int          error_cnt, n_checks;

    mees_top #(.CNT_W(48)) i_mees_top (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .horizontal_injection_starvation, .vertical_escape_slot_used,
        .vertical_egress_bypass, .vertical_egress_bypass_second, .vertical_queue_full_cycles_main,
        .vertical_queue_full_cycles_second, .vertical_queue_nonempty_cycles, .counter_overflow);

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One APB transfer; waits for pready with no assumed latency
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_d    = prdata;
        rd_e    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Drive the vector that the code names; an unknown code drives all of them
    task automatic set_cond(input logic [7:0] c, input logic [7:0] v);
        logic a;
        a = !(c inside {8'ha5, 8'h9c, 8'h9d, 8'h9e, 8'h94, 8'h95, 8'h96});
        horizontal_injection_starvation   <= (a || c == mees_pkg::EV_HORZ_STARVED) ? v : 8'h00;
        vertical_escape_slot_used         <= (a || c == mees_pkg::EV_VERT_ESCAPE) ? v : 8'h00;
        vertical_egress_bypass            <= (a || c == mees_pkg::EV_VERT_BYPASS) ? v : 8'h00;
        vertical_egress_bypass_second     <= (a || c == mees_pkg::EV_VERT_BYPASS_2) ? v[1:0] : 2'h0;
        vertical_queue_full_cycles_main   <= (a || c == mees_pkg::EV_VERT_FULL_MAIN) ? v[6:0] : 7'h00;
        vertical_queue_full_cycles_second <= (a || c == mees_pkg::EV_VERT_FULL_2ND) ? v[1:0] : 2'h0;
        vertical_queue_nonempty_cycles    <= (a || c == mees_pkg::EV_VERT_NONEMPTY) ? v[6:0] : 7'h00;
    endtask : set_cond

    // Clear and arm, hold the pattern for five edges, then read the count
    task automatic count_case(input logic [7:0] c, s, p, input logic nf, input logic [7:0] idl,
                              input logic [31:0] e);
        set_cond(c, idl);
        apb(1'b1, mees_pkg::ADDR_CTRL, {12'h000, 1'b0, 1'b1, nf, 1'b1, s, c}, 4'hf);
        set_cond(c, p);
        repeat (5) @(posedge clk);
        set_cond(c, idl);
        apb(1'b0, mees_pkg::ADDR_CNT_LO, 32'h0, 4'hf);
        chk("event count", e, rd_d);
    endtask : count_case

    // Reset values, byte lanes and the unmapped address
    task automatic reg_case();
        apb(1'b0, mees_pkg::ADDR_CTRL, 32'h0, 4'hf);
        chk("ctrl reset", 32'h00000000, rd_d);
        apb(1'b1, mees_pkg::ADDR_CTRL, 32'h000fff9c, 4'h1);
        apb(1'b0, mees_pkg::ADDR_CTRL, 32'h0, 4'hf);
        chk("ctrl lanes", 32'h0000009c, rd_d);
        apb(1'b1, 12'h010, 32'hffffffff, 4'hf);
        chk("unmapped write err", 32'h1, {31'h0, rd_e});
        apb(1'b0, 12'h010, 32'h0, 4'hf);
        chk("unmapped read err", 32'h1, {31'h0, rd_e});
        chk("unmapped read data", 32'h0, rd_d);
    endtask : reg_case

    // Wrap the counter from all ones and clear the sticky flag
    task automatic ovf_case();
        set_cond(8'h96, 8'h00);
        apb(1'b1, mees_pkg::ADDR_CTRL, 32'h00010196, 4'hf);
        apb(1'b1, mees_pkg::ADDR_CNT_LO, 32'hffffffff, 4'hf);
        apb(1'b1, mees_pkg::ADDR_CNT_HI, 32'h0000ffff, 4'hf);
        apb(1'b0, mees_pkg::ADDR_CNT_HI, 32'h0, 4'hf);
        chk("count high", 32'h0000ffff, rd_d);
        set_cond(8'h96, 8'h01);
        @(posedge clk);
        set_cond(8'h96, 8'h00);
        apb(1'b0, mees_pkg::ADDR_CNT_LO, 32'h0, 4'hf);
        chk("wrapped count", 32'h0, rd_d);
        apb(1'b0, mees_pkg::ADDR_CNT_HI, 32'h0, 4'hf);
        chk("wrapped count high", 32'h0, rd_d);
        apb(1'b0, mees_pkg::ADDR_STATUS, 32'h0, 4'hf);
        chk("status overflow", 32'h3, rd_d);
        chk("overflow pin", 32'h1, {31'h0, counter_overflow});
        apb(1'b1, mees_pkg::ADDR_STATUS, 32'h00000002, 4'hf);
        apb(1'b0, mees_pkg::ADDR_STATUS, 32'h0, 4'hf);
        chk("status cleared", 32'h1, rd_d);
        // Freeze on overflow: the wrap sets the flag, later cycles must not count
        apb(1'b1, mees_pkg::ADDR_CTRL, 32'h00090196, 4'hf);
        apb(1'b1, mees_pkg::ADDR_CNT_LO, 32'hffffffff, 4'hf);
        apb(1'b1, mees_pkg::ADDR_CNT_HI, 32'h0000ffff, 4'hf);
        set_cond(8'h96, 8'h01);
        apb(1'b0, mees_pkg::ADDR_STATUS, 32'h0, 4'hf);
        chk("status frozen", 32'h00000103, rd_d);
        apb(1'b0, mees_pkg::ADDR_CNT_LO, 32'h0, 4'hf);
        chk("frozen count", 32'h0, rd_d);
        set_cond(8'h96, 8'h00);
    endtask : ovf_case

    // Watchdog well beyond the roughly two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        error_cnt = 0;
        n_checks  = 0;
        resetn    = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        set_cond(8'h00, 8'h00);
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        reg_case();
        count_case(8'ha5, 8'hff, 8'hff, 1'b0, 8'h00, 32'd25);
        count_case(8'ha5, 8'h05, 8'h05, 1'b0, 8'h00, 32'd10);
        count_case(8'h9c, 8'hff, 8'hff, 1'b0, 8'h00, 32'd20);
        count_case(8'h9d, 8'hff, 8'hff, 1'b0, 8'h00, 32'd35);
        count_case(8'h9e, 8'hff, 8'h03, 1'b0, 8'h00, 32'd10);
        count_case(8'h94, 8'h7f, 8'h7f, 1'b0, 8'h00, 32'd35);
        count_case(8'h94, 8'h7f, 8'h0f, 1'b1, 8'h7f, 32'd15);
        count_case(8'h95, 8'h03, 8'h01, 1'b0, 8'h00, 32'd5);
        count_case(8'h96, 8'h48, 8'hff, 1'b0, 8'h00, 32'd10);
        count_case(8'h97, 8'hff, 8'hff, 1'b0, 8'h00, 32'd0);
        count_case(8'h96, 8'h00, 8'hff, 1'b0, 8'h00, 32'd0);
        ovf_case();
        end_sim();
    end
endmodule : mees_top_tb

`default_nettype wire
